// [design/afc_pkg.sv]
// package for the converter flow control and interrupt enable block
// assumes a classic wishbone slave with 32-bit data and byte addressing
package afc_pkg;
    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [3:0] AFC_IDX_ERR_IE = 4'h6;
    localparam logic [3:0] AFC_IDX_EVT_IE = 4'h7;
    localparam logic [3:0] AFC_IDX_ERR_FLG = 4'h8;
    localparam logic [3:0] AFC_IDX_CTRL = 4'h0;
    localparam logic [3:0] AFC_IDX_STAT = 4'h1;
    localparam logic [3:0] AFC_IDX_EVT_FLG = 4'h2;
    localparam logic [3:0] AFC_IDX_MODE = 4'h3;
    localparam int AFC_ADDR_W = 6;

    // ==========================================================
    // error enable / flag bit positions
    localparam int AFC_B_IA = 7;
    localparam int AFC_B_CMD = 6;
    localparam int AFC_B_EOL = 5;
    localparam int AFC_B_TRIGGER_REQUEST = 3;
    localparam int AFC_B_RSTAR = 2;
    localparam int AFC_B_LOAD_OK = 1;
    // event enable / flag bit positions
    localparam int AFC_B_ABORT_DONE = 7;
    localparam int AFC_B_OVERRUN = 6;
    // control register bit positions (write one = request)
    localparam int AFC_C_RESTART = 3;
    localparam int AFC_C_TRIGGER = 2;
    localparam int AFC_C_ABORT = 1;
    localparam int AFC_C_LOAD_OK = 0;
    localparam int AFC_C_SOFT_RST = 7;

    // ==========================================================
    // reset values and write/fatal masks
    localparam logic [7:0] AFC_RST_ERR_IE = 8'h00;
    localparam logic [7:0] AFC_RST_EVT_IE = 8'h00;
    localparam logic [7:0] AFC_RST_FLAGS = 8'h00;
    localparam logic [7:0] AFC_ERR_IE_MASK = 8'hEE;
    localparam logic [7:0] AFC_EVT_IE_MASK = 8'hC0;
    localparam logic [7:0] AFC_FATAL_MASK = 8'hE8;

    typedef enum logic {AFC_MODE_RESTART, AFC_MODE_TRIGGER} afc_mode_t;

    // one set of simultaneous flow control requests
    typedef struct packed {
        logic restart_request;
        logic trigger_request;
        logic sequence_abort_request;
        logic load_ok;
    } afc_req_t;

    // actions decoded from a request set
    typedef struct packed {
        logic swap_list;
        logic start_seq;
        logic load_top;
        logic abort_all;
        logic auto_trigger;
        logic trigger_error;
    } afc_act_t;
endpackage

// [design/afc_decode.sv]
// decodes one set of flow control requests into actions
// assumes requests and mode are sampled in the same cycle by the caller
`timescale 1ns/100ps
module afc_decode
    import afc_pkg::*;
(
    // request set and mode
    input wire afc_pkg::afc_req_t req,
    input wire afc_pkg::afc_mode_t mode,
    // decoded actions
    output afc_pkg::afc_act_t act
);
    always_comb begin
        act = '0;
        act.abort_all = req.sequence_abort_request;
        if (req.restart_request && req.trigger_request && mode == AFC_MODE_RESTART) begin
            act.trigger_error = 1'b1;
        end else begin
            act.load_top = req.restart_request;
            act.swap_list = req.restart_request & req.load_ok;
            // trigger mode auto trigger; start on a trigger request in either mode
            act.auto_trigger = req.restart_request & req.trigger_request;
            act.start_seq = req.trigger_request;
        end
    end
endmodule

// [design/afc_top.sv]
// flow control decode, error/event flags and interrupt enables of a converter sequencer
// assumes a classic wishbone master on clk; converter datapath events arrive as pulses
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
module afc_top
    import afc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [AFC_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // converter datapath events (one-cycle pulses)
    input wire logic illegal_access_evt,
    input wire logic command_value_evt,
    input wire logic list_end_missing_evt,
    input wire logic abort_done_evt,
    input wire logic flag_overrun_evt,
    input wire logic restart_no_load_evt,
    // decoded actions to the datapath (one-cycle pulses) and the halted level
    output afc_pkg::afc_act_t act_o,
    output logic halted_o,
    // interrupt outputs
    output logic err_irq_o,
    output logic evt_irq_o,
    output logic irq_o
);
    import afc_pkg::*;

    // ==========================================================
    // bus decode
    function automatic logic hit(input logic [AFC_ADDR_W-1:0] a, input logic [3:0] idx);
        hit = (a[AFC_ADDR_W-1:2] == idx);
    endfunction

    logic req_v;
    logic wr_v;
    logic rd_v;
    logic mapped;
    assign req_v = cyc_i & stb_i & ~ack_o & ~err_o;
    assign wr_v = req_v & we_i & sel_i[0];
    assign rd_v = req_v & ~we_i;
    assign mapped = hit(adr_i, AFC_IDX_ERR_IE) | hit(adr_i, AFC_IDX_EVT_IE)
                  | hit(adr_i, AFC_IDX_ERR_FLG) | hit(adr_i, AFC_IDX_CTRL)
                  | hit(adr_i, AFC_IDX_STAT) | hit(adr_i, AFC_IDX_EVT_FLG)
                  | hit(adr_i, AFC_IDX_MODE);

    // ==========================================================
    // request decode
    afc_req_t req;
    afc_act_t act;
    logic soft_rst;
    logic ctrl_wr;
    assign ctrl_wr = wr_v & hit(adr_i, AFC_IDX_CTRL);
    assign soft_rst = ctrl_wr & dat_i[AFC_C_SOFT_RST];

    logic [7:0] err_ie_q, err_ie_d;
    logic [7:0] evt_ie_q, evt_ie_d;
    logic [7:0] err_flg_q, err_flg_d;
    logic [7:0] evt_flg_q, evt_flg_d;
    afc_mode_t mode_q, mode_d;
    logic halted;

    // requests are ignored while a severe error stands
    assign halted = |(err_flg_q & AFC_FATAL_MASK);

    always_comb begin
        req = '0;
        if (ctrl_wr && !halted) begin
            req.restart_request = dat_i[AFC_C_RESTART];
            req.trigger_request = dat_i[AFC_C_TRIGGER];
            req.sequence_abort_request = dat_i[AFC_C_ABORT];
            req.load_ok = dat_i[AFC_C_LOAD_OK];
        end
    end

    afc_decode u_dec (
        .req(req),
        .mode(mode_q),
        .act(act)
    );

    // ==========================================================
    // registers and flags
    always_comb begin
        err_ie_d = err_ie_q;
        evt_ie_d = evt_ie_q;
        mode_d = mode_q;
        err_flg_d = err_flg_q;
        evt_flg_d = evt_flg_q;
        if (wr_v && hit(adr_i, AFC_IDX_ERR_IE)) begin
            err_ie_d = dat_i[7:0] & AFC_ERR_IE_MASK;
        end
        if (wr_v && hit(adr_i, AFC_IDX_EVT_IE)) begin
            evt_ie_d = dat_i[7:0] & AFC_EVT_IE_MASK;
        end
        if (wr_v && hit(adr_i, AFC_IDX_MODE)) begin
            mode_d = afc_mode_t'(dat_i[0]);
        end
        // write one clears the two soft errors
        if (wr_v && hit(adr_i, AFC_IDX_ERR_FLG)) begin
            err_flg_d[AFC_B_RSTAR] = err_flg_d[AFC_B_RSTAR] & ~dat_i[AFC_B_RSTAR];
            err_flg_d[AFC_B_LOAD_OK] = err_flg_d[AFC_B_LOAD_OK] & ~dat_i[AFC_B_LOAD_OK];
        end
        // event flags clear on read
        if (rd_v && hit(adr_i, AFC_IDX_EVT_FLG)) begin
            evt_flg_d = AFC_RST_FLAGS;
        end
        // soft reset clears every error flag
        if (soft_rst) begin
            err_flg_d = AFC_RST_FLAGS;
        end
        // sets win over clears
        if (illegal_access_evt) begin
            err_flg_d[AFC_B_IA] = 1'b1;
        end
        if (command_value_evt) begin
            err_flg_d[AFC_B_CMD] = 1'b1;
        end
        if (list_end_missing_evt) begin
            err_flg_d[AFC_B_EOL] = 1'b1;
        end
        if (act.trigger_error) begin
            err_flg_d[AFC_B_TRIGGER_REQUEST] = 1'b1;
        end
        if (restart_no_load_evt) begin
            err_flg_d[AFC_B_LOAD_OK] = 1'b1;
        end
        if (req.restart_request && req.trigger_request && mode_q == AFC_MODE_TRIGGER
            && req.load_ok && !req.sequence_abort_request) begin
            err_flg_d[AFC_B_RSTAR] = err_flg_d[AFC_B_RSTAR];
        end
        if (abort_done_evt) begin
            evt_flg_d[AFC_B_ABORT_DONE] = 1'b1;
        end
        // overrun of any done flag or list end flag
        if (flag_overrun_evt) begin
            evt_flg_d[AFC_B_OVERRUN] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_ie_q <= AFC_RST_ERR_IE;
            evt_ie_q <= AFC_RST_EVT_IE;
            err_flg_q <= AFC_RST_FLAGS;
            evt_flg_q <= AFC_RST_FLAGS;
            mode_q <= AFC_MODE_RESTART;
        end else begin
            err_ie_q <= err_ie_d;
            evt_ie_q <= evt_ie_d;
            err_flg_q <= err_flg_d;
            evt_flg_q <= evt_flg_d;
            mode_q <= mode_d;
        end
    end

    // ==========================================================
    // bus answer, action pulses and interrupt outputs
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(adr_i, AFC_IDX_ERR_IE)) begin
            rdata[7:0] = err_ie_q;
        end else if (hit(adr_i, AFC_IDX_EVT_IE)) begin
            rdata[7:0] = evt_ie_q;
        end else if (hit(adr_i, AFC_IDX_ERR_FLG)) begin
            rdata[7:0] = err_flg_q;
        end else if (hit(adr_i, AFC_IDX_EVT_FLG)) begin
            rdata[7:0] = evt_flg_q;
        end else if (hit(adr_i, AFC_IDX_MODE)) begin
            rdata[0] = mode_q;
        end else if (hit(adr_i, AFC_IDX_STAT)) begin
            rdata[0] = halted;
        end
    end

    logic ack_d, err_d;
    logic [31:0] dat_d;
    afc_act_t act_d;
    logic err_irq_d, evt_irq_d;
    always_comb begin
        ack_d = req_v & mapped;
        err_d = req_v & ~mapped;
        dat_d = rd_v ? rdata : 32'h0000_0000;
        act_d = act;
        err_irq_d = |(err_flg_d & err_ie_d);
        evt_irq_d = |(evt_flg_d & evt_ie_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            act_o <= '0;
            halted_o <= 1'b0;
            err_irq_o <= 1'b0;
            evt_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            ack_o <= ack_d;
            err_o <= err_d;
            dat_o <= dat_d;
            act_o <= act_d;
            halted_o <= |(err_flg_d & AFC_FATAL_MASK);
            err_irq_o <= err_irq_d;
            evt_irq_o <= evt_irq_d;
            irq_o <= err_irq_d | evt_irq_d;
        end
    end

    // ==========================================================
    // checks
    chk_trigger_request_err_flag: assert property (@(posedge clk) disable iff (rst)
        act.trigger_error |=> err_flg_q[AFC_B_TRIGGER_REQUEST])
        else $error("trigger error not flagged");
    chk_restart_refused: assert property (@(posedge clk) disable iff (rst)
        (mode_q == AFC_MODE_RESTART && req.restart_request && req.trigger_request)
        |-> !act.load_top && !act.start_seq)
        else $error("refused combination acted");
    chk_abort_pulse: assert property (@(posedge clk) disable iff (rst)
        req.sequence_abort_request |=> act_o.abort_all)
        else $error("abort not issued");
    chk_restart_load: assert property (@(posedge clk) disable iff (rst)
        (req.restart_request && !act.trigger_error) |=> act_o.load_top)
        else $error("restart did not load top");
    chk_auto_trigger: assert property (@(posedge clk) disable iff (rst)
        (mode_q == AFC_MODE_TRIGGER && req.restart_request && req.trigger_request)
        |=> act_o.auto_trigger && act_o.start_seq)
        else $error("auto trigger missing");
    chk_err_irq_gate: assert property (@(posedge clk) disable iff (rst)
        err_irq_o == |(err_flg_q & err_ie_q))
        else $error("error interrupt not gated by enable");
    chk_evt_irq_gate: assert property (@(posedge clk) disable iff (rst)
        evt_irq_o == |(evt_flg_q & evt_ie_q))
        else $error("event interrupt not gated by enable");
    chk_enable_write: assert property (@(posedge clk) disable iff (rst)
        (wr_v && hit(adr_i, AFC_IDX_ERR_IE)) |=> err_ie_q == ($past(dat_i[7:0]) & AFC_ERR_IE_MASK))
        else $error("error enable write lost");
    chk_halt_hold: assert property (@(posedge clk) disable iff (rst)
        (halted && !soft_rst) |=> halted)
        else $error("severe error left without soft reset");
    chk_soft_err_go: assert property (@(posedge clk) disable iff (rst)
        (restart_no_load_evt && !halted && !illegal_access_evt && !command_value_evt
            && !list_end_missing_evt && !act.trigger_error) |=> !halted_o)
        else $error("soft error stopped conversion");

    // ==========================================================
    // flag, halt and action checks
    chk_flag_w1c: assert property (@(posedge clk) disable iff (rst)
        (wr_v && hit(adr_i, AFC_IDX_ERR_FLG) && dat_i[AFC_B_LOAD_OK] && !restart_no_load_evt)
        |=> !err_flg_q[AFC_B_LOAD_OK])
        else $error("write one left load ok error set");
    chk_flag_w0_keeps: assert property (@(posedge clk) disable iff (rst)
        (wr_v && hit(adr_i, AFC_IDX_ERR_FLG) && !dat_i[AFC_B_LOAD_OK] && err_flg_q[AFC_B_LOAD_OK])
        |=> err_flg_q[AFC_B_LOAD_OK])
        else $error("write zero cleared load ok error");
    chk_severe_stop: assert property (@(posedge clk) disable iff (rst)
        (illegal_access_evt || command_value_evt || list_end_missing_evt)
        |=> halted_o)
        else $error("severe error did not stop conversion");
    chk_soft_rst_clear: assert property (@(posedge clk) disable iff (rst)
        (soft_rst && !illegal_access_evt && !command_value_evt && !list_end_missing_evt
            && !act.trigger_error) |=> !halted_o)
        else $error("soft reset left conversion stopped");
    chk_halted_out: assert property (@(posedge clk) disable iff (rst)
        halted_o == halted)
        else $error("halted output differs from severe flags");
    chk_halt_blocks: assert property (@(posedge clk) disable iff (rst)
        halted |-> act == '0)
        else $error("action issued while halted");
    chk_stat_read: assert property (@(posedge clk) disable iff (rst)
        (rd_v && hit(adr_i, AFC_IDX_STAT)) |=> dat_o[0] == $past(halted))
        else $error("status read lost halted state");
    chk_act_quiet: assert property (@(posedge clk) disable iff (rst)
        !ctrl_wr |=> act_o == '0)
        else $error("action pulse without control write");
    chk_trigger_request_mode_ok: assert property (@(posedge clk) disable iff (rst)
        (mode_q == AFC_MODE_TRIGGER) |-> !act.trigger_error)
        else $error("trigger error raised in trigger mode");
    chk_irq_or: assert property (@(posedge clk) disable iff (rst)
        irq_o == (err_irq_o || evt_irq_o))
        else $error("summary interrupt differs from its sources");
    chk_evt_clear_read: assert property (@(posedge clk) disable iff (rst)
        (rd_v && hit(adr_i, AFC_IDX_EVT_FLG) && !abort_done_evt && !flag_overrun_evt)
        |=> evt_flg_q == AFC_RST_FLAGS)
        else $error("event flags not cleared by read");
    chk_evt_ie_write: assert property (@(posedge clk) disable iff (rst)
        (wr_v && hit(adr_i, AFC_IDX_EVT_IE))
        |=> evt_ie_q == ($past(dat_i[7:0]) & AFC_EVT_IE_MASK))
        else $error("event enable write lost");
    chk_err_ie_read: assert property (@(posedge clk) disable iff (rst)
        (rd_v && hit(adr_i, AFC_IDX_ERR_IE)) |=> dat_o[7:0] == $past(err_ie_q))
        else $error("error enable read wrong");
    chk_evt_ie_read: assert property (@(posedge clk) disable iff (rst)
        (rd_v && hit(adr_i, AFC_IDX_EVT_IE)) |=> dat_o[7:0] == $past(evt_ie_q))
        else $error("event enable read wrong");

    // ==========================================================
    // bus handshake checks
    // ack is registered, so a request is answered in the next cycle and then dropped
    sequence bus_take_s;
        cyc_i && stb_i && !ack_o && !err_o;
    endsequence
    sequence bus_answer_s;
        (ack_o ^ err_o) ##1 !(ack_o || err_o);
    endsequence
    chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
        bus_take_s |=> bus_answer_s)
        else $error("bus request not answered for one cycle");
    chk_unmapped_err: assert property (@(posedge clk) disable iff (rst)
        (req_v && !mapped) |=> err_o && !ack_o)
        else $error("unmapped access not refused");
endmodule

// [test/afc_top_test.sv]
// testbench for afc_top: register bus, flow control decode, interrupt enables
// assumes the design answers every wishbone request and drops ack by itself
`timescale 1ns/100ps
module afc_top_test;
    import afc_pkg::*;
    logic clk, rst, cyc, stb, we, bus_err;
    logic [5:0] adr;
    logic [5:0] evts;
    logic [31:0] wdat, dat_o, rd;
    logic ack_o, err_o, halted_o, err_irq_o, evt_irq_o, irq_o;
    afc_act_t act_o, act_seen;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    // trigger mode entries first; the restart mode trigger error halts, so it comes last
    logic tmode [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0] code [8] = '{8'h08, 8'h09, 8'h0A, 8'h02, 8'h0C, 8'h0F, 8'h0B, 8'h0C};
    logic [5:0] want [8] = '{6'h08, 6'h28, 6'h0C, 6'h04, 6'h1A, 6'h3E, 6'h2C, 6'h01};

    afc_top i_afc_top (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .illegal_access_evt(evts[0]), .command_value_evt(evts[1]),
        .list_end_missing_evt(evts[2]), .abort_done_evt(evts[3]),
        .flag_overrun_evt(evts[4]), .restart_no_load_evt(evts[5]), .act_o(act_o),
        .halted_o(halted_o), .err_irq_o(err_irq_o), .evt_irq_o(evt_irq_o), .irq_o(irq_o));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // checking and closing
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // the run should end well before this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report;
        end
    end

    // ==========================================================
    // bus and event tasks
    // actions pulse together with ack, so they are taken at the ack edge;
    // only the bench timeout ends a wait for the answer
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        act_seen = act_o;
        bus_err = err_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, {24'h000000, exp});
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        evts <= 6'h01 << b;
        @(posedge clk);
        evts <= 6'h00;
        settle;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        wdat = 32'h00000000;
        evts = 6'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(AFC_IDX_ERR_IE, AFC_RST_ERR_IE);
        rd_chk(AFC_IDX_EVT_IE, AFC_RST_EVT_IE);
        wr(AFC_IDX_ERR_IE, 8'hFF);
        wr(AFC_IDX_EVT_IE, 8'hFF);
        rd_chk(AFC_IDX_ERR_IE, AFC_ERR_IE_MASK);
        rd_chk(AFC_IDX_EVT_IE, AFC_EVT_IE_MASK);
        bus(1'b0, 4'h9, 8'h00);
        check(bus_err, 1'b1);
        wr(AFC_IDX_ERR_IE, 8'h00);
        wr(AFC_IDX_EVT_IE, 8'h00);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            check(halted_o, 1'b1);
            check(err_irq_o, 1'b0);
            wr(AFC_IDX_ERR_IE, 8'h80 >> i);
            settle;
            check(err_irq_o, 1'b1);
            check(irq_o, 1'b1);
            wr(AFC_IDX_CTRL, 8'h08);
            check(act_seen, 6'h00);
            wr(AFC_IDX_CTRL, 8'h80);
            settle;
            check(halted_o, 1'b0);
            check(err_irq_o, 1'b0);
        end
        wr(AFC_IDX_ERR_IE, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(AFC_IDX_MODE, {7'h00, tmode[k]});
            wr(AFC_IDX_CTRL, code[k]);
            check(act_seen, want[k]);
        end
        settle;
        rd_chk(AFC_IDX_ERR_FLG, 8'h08);
        check(halted_o, 1'b1);
        check(err_irq_o, 1'b0);
        wr(AFC_IDX_ERR_IE, 8'h08);
        settle;
        check(err_irq_o, 1'b1);
        wr(AFC_IDX_CTRL, 8'h80);
        settle;
        check(err_irq_o, 1'b0);
        for (int i = 0; i < 2; i++) begin
            pulse(3 + i);
            check(evt_irq_o, 1'b0);
            rd_chk(AFC_IDX_EVT_FLG, 8'h80 >> i);
            rd_chk(AFC_IDX_EVT_FLG, 8'h00);
            wr(AFC_IDX_EVT_IE, 8'h80 >> i);
            pulse(3 + i);
            check(evt_irq_o, 1'b1);
            check(irq_o, 1'b1);
            bus(1'b0, AFC_IDX_EVT_FLG, 8'h00);
            check(rd, {24'h000000, 8'h80 >> i});
            settle;
            check(evt_irq_o, 1'b0);
            wr(AFC_IDX_EVT_IE, 8'h00);
        end
        wr(AFC_IDX_ERR_IE, 8'h06);
        pulse(5);
        check(halted_o, 1'b0);
        check(err_irq_o, 1'b1);
        wr(AFC_IDX_ERR_FLG, 8'h00);
        settle;
        check(err_irq_o, 1'b1);
        wr(AFC_IDX_ERR_FLG, 8'h06);
        settle;
        rd_chk(AFC_IDX_ERR_FLG, 8'h00);
        check(err_irq_o, 1'b0);
        final_report;
    end
endmodule
